// >>> core/hlt_cfg.svh
// Constants for the hardware limit timer control block
`ifndef HLT_CFG_SVH
`define HLT_CFG_SVH

// ==========================================================================
// Widths
`define HLT_CNT_W 8
`define HLT_MODE_W 5

// ==========================================================================
// Mode codes
`define HLT_MODE_SW_GATE 5'h00
`define HLT_MODE_LIM_ANY 5'h03
`define HLT_MODE_LIM_FALL 5'h05
`define HLT_MODE_LVL_LOW 5'h06
`define HLT_MODE_LVL_HIGH 5'h07
`define HLT_MODE_OS_SW 5'h08
`define HLT_MODE_OS_RISE 5'h09
`define HLT_MODE_OS_ANY 5'h0b
`define HLT_MODE_ELOS_RISE 5'h0c
`define HLT_MODE_ELOS_FALL 5'h0d
`define HLT_MODE_LEOS_LOW 5'h0e
`define HLT_MODE_LEOS_HIGH 5'h0f
`define HLT_MODE_MONO_RISE 5'h11
`define HLT_MODE_MONO_ANY 5'h13
`define HLT_MODE_LLOS_LOW 5'h16
`define HLT_MODE_LLOS_HIGH 5'h17

// ==========================================================================
// Edge selection by low three mode bits
`define HLT_SEL_ANY 3'h3
`define HLT_SEL_RISE_A 3'h1
`define HLT_SEL_RISE_B 3'h4
`define HLT_SEL_RISE_C 3'h6

// ==========================================================================
// Reset values and timing
`define HLT_COUNT_RST 8'h00
`define HLT_HOLD_RST 2'h0
`define HLT_RESTART_TICKS 2'h2

`endif

// >>> core/hlt_pkg.sv
// Types shared by the hardware limit timer control block
package hlt_pkg;

  // ========================================================================
  // Control state
  typedef enum logic [1:0] {
    ST_WAIT,
    ST_RUN,
    ST_HOLD
  } hlt_state_e;

  // ========================================================================
  // Configuration carried into the block
  typedef struct packed {
    logic [4:0] mode;
    logic [7:0] period_value;
    logic [7:0] pulse_width_value;
    logic prescaler_sync_enable;
    logic internal_osc_selected;
  } hlt_cfg_s;

  // ========================================================================
  // Status carried out of the block
  typedef struct packed {
    logic on_bit;
    logic [7:0] count_value;
    logic pwm_drive;
    logic period_match;
    logic osc_keep_alive;
  } hlt_stat_s;

endpackage : hlt_pkg

// >>> core/hlt_ers_sync.sv
// Two-stage synchroniser for the external trigger signal
`timescale 1ns/10ps

module hlt_ers_sync
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Signal
  input wire logic external_trigger_signal,
  output logic ers_sync
);

  logic ers_meta;

  // ========================================================================
  // Stage one is read only by stage two
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ers_meta <= 1'b0;
      ers_sync <= 1'b0;
    end
    else
    begin
      ers_meta <= external_trigger_signal;
      ers_sync <= ers_meta;
    end
  end

endmodule : hlt_ers_sync

// >>> core/hlt_timer.sv
// Mode-dependent start, stop and reset control of an 8-bit period timer
// Functional notes
// - Edge limit modes reset count on selected external edge before match
// - Early edge reset shortens period, restarts pulse after two clocks
// - Level limit modes hold count reset while signal at reset level
// - Level limit modes ignore external signal while run bit clear
// - Level limit: reset on match or two clocks after steady reset
// - Level limit: restart after match, or two clocks after release
// - Level limit: pulse held high through reset until width reached
// - Software one-shot: match resets count and clears run bit
// - Software one-shot restarts only by set after match; clear pauses
// - Edge one-shot starts on edge after run set; match clears run
// - Edge one-shot needs fresh edge after run bit set again
// - Edge limit one-shot: first edge starts, later edges reset count
// - Edge limit one-shot resumes two clocks after each reset edge
// - Edge limit one-shot ignores edges until run set; match clears run
// - Level-reset edge one-shot holds at reset level, starts on edge
// - Level-reset edge one-shot needs new edge after run bit cleared
// - Monostable starts on edge after run set, stops at match
// - Monostable ignores edges while counting, no pulse on match
// - Level limit one-shot counts when run set and signal inactive
// - Level limit one-shot: software clear stops without clearing count
// - Prescaler sync enabled: timer frozen in sleep, values unchanged
// - Prescaler sync disabled: timer runs in sleep, internal oscillator kept alive if selected
// - Clearing run bit returns edge-start modes to wait state and drops any restart hold
// - Count equal to period clears count on following clock
`timescale 1ns/10ps
`include "hlt_cfg.svh"

module hlt_timer
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Timer clock enable from the selected source
  input wire logic timer_tick,
  // Software run bit access
  input wire logic sw_on_set,
  input wire logic sw_on_clr,
  // Configuration
  input wire hlt_pkg::hlt_cfg_s cfg,
  // System state and external signal
  input wire logic sleep,
  input wire logic external_trigger_signal,
  // Status
  output hlt_pkg::hlt_stat_s stat
);

  // ========================================================================
  // State
  logic on_bit;
  logic [`HLT_CNT_W-1:0] count;
  logic [1:0] hold_cnt;
  hlt_pkg::hlt_state_e state;
  logic pwm_drive;
  logic period_match;
  logic osc_keep_alive;
  logic ers_sync;
  logic ers_q;
  logic ers_qq;

  logic [`HLT_CNT_W-1:0] next_count;
  logic [1:0] next_hold;
  hlt_pkg::hlt_state_e next_state;
  logic hw_clr;
  logic pwm_set;
  logic pwm_clr;

  hlt_ers_sync u_sync
  (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .external_trigger_signal(external_trigger_signal),
    .ers_sync(ers_sync)
  );

  // ========================================================================
  // Decode
  wire [4:0] mode = cfg.mode;
  wire frozen = sleep & cfg.prescaler_sync_enable;
  wire adv = timer_tick & ~frozen;
  wire match = (count == cfg.period_value);
  wire width_hit = (count == cfg.pulse_width_value);
  wire rise = ers_q & ~ers_qq;
  wire fall = ~ers_q & ers_qq;
  wire sel_any = (mode[2:0] == `HLT_SEL_ANY);
  wire sel_rise = (mode[2:0] == `HLT_SEL_RISE_A) |
                  (mode[2:0] == `HLT_SEL_RISE_B) |
                  (mode[2:0] == `HLT_SEL_RISE_C);
  wire qual_edge = sel_any ? (rise | fall) : (sel_rise ? rise : fall);
  // Low mode bit picks the reset level in every level-type mode
  wire reset_lvl = mode[0] ? ers_q : ~ers_q;

  wire g_edge_lim = (mode >= `HLT_MODE_LIM_ANY) &&
                    (mode <= `HLT_MODE_LIM_FALL);
  wire g_lvl_lim = (mode == `HLT_MODE_LVL_LOW) ||
                   (mode == `HLT_MODE_LVL_HIGH);
  wire g_sw_os = (mode == `HLT_MODE_OS_SW);
  wire g_edge_os = (mode >= `HLT_MODE_OS_RISE) &&
                   (mode <= `HLT_MODE_OS_ANY);
  wire g_elim_os = (mode == `HLT_MODE_ELOS_RISE) ||
                   (mode == `HLT_MODE_ELOS_FALL);
  wire g_ledge_os = (mode == `HLT_MODE_LEOS_LOW) ||
                    (mode == `HLT_MODE_LEOS_HIGH);
  wire g_mono = (mode >= `HLT_MODE_MONO_RISE) &&
                (mode <= `HLT_MODE_MONO_ANY);
  wire g_llim_os = (mode == `HLT_MODE_LLOS_LOW) ||
                   (mode == `HLT_MODE_LLOS_HIGH);
  wire one_shot = g_sw_os | g_edge_os | g_elim_os | g_ledge_os | g_llim_os;
  wire edge_start = g_edge_os | g_elim_os | g_ledge_os | g_mono;
  wire lvl_type = g_lvl_lim | g_llim_os | g_ledge_os;
  wire edge_reset = g_edge_lim | g_elim_os;

  // ========================================================================
  // Next-state decision, applied only on an active timer tick
  always_comb
  begin
    next_count = count;
    next_hold = hold_cnt;
    next_state = state;
    hw_clr = 1'b0;
    pwm_set = 1'b0;
    pwm_clr = 1'b0;
    if (!on_bit)
    begin
      // Off: arming logic returns to rest, count is kept except at reset level in level-reset edge one-shot
      next_hold = `HLT_HOLD_RST;
      if (edge_start)
        next_state = hlt_pkg::ST_WAIT;
      else if (state == hlt_pkg::ST_HOLD)
        next_state = hlt_pkg::ST_RUN;
      if (g_ledge_os && reset_lvl)
        next_count = `HLT_COUNT_RST;
    end
    else
    begin
      case (state)
        hlt_pkg::ST_WAIT:
        begin
          if (lvl_type && reset_lvl)
            next_count = `HLT_COUNT_RST;
          if (edge_start)
          begin
            if (qual_edge && !(g_ledge_os && reset_lvl))
            begin
              next_state = hlt_pkg::ST_RUN;
              pwm_set = 1'b1;
            end
          end
          else if (!(lvl_type && reset_lvl))
          begin
            next_state = hlt_pkg::ST_RUN;
            pwm_set = 1'b1;
          end
        end
        hlt_pkg::ST_RUN:
        begin
          pwm_clr = width_hit;
          if (edge_reset && qual_edge)
          begin
            // Early reset shortens the period, restart after hold
            next_count = `HLT_COUNT_RST;
            next_hold = `HLT_RESTART_TICKS;
            next_state = hlt_pkg::ST_HOLD;
          end
          else if (lvl_type && reset_lvl)
          begin
            next_count = `HLT_COUNT_RST;
            next_state = hlt_pkg::ST_WAIT;
            pwm_clr = 1'b0;
          end
          else if (match)
          begin
            next_count = `HLT_COUNT_RST;
            if (one_shot)
            begin
              hw_clr = 1'b1;
              next_state = hlt_pkg::ST_WAIT;
            end
            else if (g_mono)
              next_state = hlt_pkg::ST_WAIT;
            else
              pwm_set = 1'b1;
          end
          else
            next_count = 8'(count + 8'h01);
        end
        hlt_pkg::ST_HOLD:
        begin
          next_count = `HLT_COUNT_RST;
          if (hold_cnt <= 2'h1)
          begin
            next_hold = `HLT_HOLD_RST;
            next_state = hlt_pkg::ST_RUN;
            pwm_set = 1'b1;
          end
          else
            next_hold = 2'(hold_cnt - 2'h1);
        end
        default:
          next_state = hlt_pkg::ST_WAIT;
      endcase
    end
  end

  // ========================================================================
  // Trigger sampling on timer ticks
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ers_q <= 1'b0;
      ers_qq <= 1'b0;
    end
    else if (adv)
    begin
      ers_q <= ers_sync;
      ers_qq <= ers_q;
    end
  end

  // ========================================================================
  // Run bit: a software set wins over any clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      on_bit <= 1'b0;
    else if (sw_on_set)
      on_bit <= 1'b1;
    else if (sw_on_clr || (adv && hw_clr))
      on_bit <= 1'b0;
  end

  // ========================================================================
  // Counter and control state; nothing moves while frozen in sleep
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= `HLT_COUNT_RST;
      hold_cnt <= `HLT_HOLD_RST;
      state <= hlt_pkg::ST_WAIT;
    end
    else if (adv)
    begin
      count <= next_count;
      hold_cnt <= next_hold;
      state <= next_state;
    end
  end

  // ========================================================================
  // Pulse drive toward the compare unit, set wins over clear
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwm_drive <= 1'b0;
      period_match <= 1'b0;
    end
    else
    begin
      period_match <= adv && on_bit && (state == hlt_pkg::ST_RUN) && match;
      if (adv && pwm_set)
        pwm_drive <= 1'b1;
      else if (adv && pwm_clr)
        pwm_drive <= 1'b0;
    end
  end

  // ========================================================================
  // Oscillator request in sleep
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      osc_keep_alive <= 1'b0;
    else
      osc_keep_alive <= sleep & ~cfg.prescaler_sync_enable &
                        cfg.internal_osc_selected;
  end

  assign stat = '{on_bit: on_bit, count_value: count, pwm_drive: pwm_drive,
                  period_match: period_match, osc_keep_alive: osc_keep_alive};

  // ========================================================================
  // Checks
  sequence s_run_tick;
    adv && on_bit && (state == hlt_pkg::ST_RUN);
  endsequence

  sequence s_edge_hit;
    s_run_tick and (edge_reset && qual_edge);
  endsequence

  property p_edge_reset;
    @(posedge sys_clk) disable iff (!rst_n)
      s_edge_hit |=> (count == 8'h00) && (state == hlt_pkg::ST_HOLD);
  endproperty
  a_edge_reset: assert property (p_edge_reset)
    else $error("edge reset did not clear count");

  property p_restart_delay;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_edge_hit and g_elim_os && !sw_on_clr) |=>
        (hold_cnt == 2'h2) ##1 (!adv || on_bit == 1'b0 || hold_cnt == 2'h1);
  endproperty
  a_restart_delay: assert property (p_restart_delay)
    else $error("restart hold not two ticks");

  property p_lvl_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_run_tick and (g_lvl_lim && reset_lvl)) |=>
        (count == 8'h00) && (state == hlt_pkg::ST_WAIT);
  endproperty
  a_lvl_hold: assert property (p_lvl_hold)
    else $error("level reset not held");

  property p_lvl_ignore;
    @(posedge sys_clk) disable iff (!rst_n)
      (adv && !on_bit && g_lvl_lim) |=> $stable(count);
  endproperty
  a_lvl_ignore: assert property (p_lvl_ignore)
    else $error("external signal acted while off");

  property p_rollover;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_run_tick and match) |=> (count == 8'h00);
  endproperty
  a_rollover: assert property (p_rollover)
    else $error("count not cleared after period match");

  property p_oneshot_clr;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_run_tick and (g_sw_os && match && !sw_on_set)) |=>
        !on_bit && (state == hlt_pkg::ST_WAIT);
  endproperty
  a_oneshot_clr: assert property (p_oneshot_clr)
    else $error("one-shot did not clear run bit");

  property p_mono_stop;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_run_tick and (g_mono && match && !sw_on_clr)) |=>
        on_bit && (state == hlt_pkg::ST_WAIT) && $stable(pwm_drive);
  endproperty
  a_mono_stop: assert property (p_mono_stop)
    else $error("monostable did not stop at match");

  property p_frozen;
    @(posedge sys_clk) disable iff (!rst_n)
      frozen |=> $stable(count) && $stable(state);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("timer moved while frozen in sleep");

  property p_edge_wait;
    @(posedge sys_clk) disable iff (!rst_n)
      (adv && state == hlt_pkg::ST_WAIT && g_edge_os && !qual_edge) |=>
        (state == hlt_pkg::ST_WAIT) && $stable(count);
  endproperty
  a_edge_wait: assert property (p_edge_wait)
    else $error("edge one-shot started without edge");

  property p_pwm_keep;
    @(posedge sys_clk) disable iff (!rst_n)
      (pwm_drive && g_lvl_lim && state == hlt_pkg::ST_WAIT) |=> pwm_drive;
  endproperty
  a_pwm_keep: assert property (p_pwm_keep)
    else $error("pulse dropped during level reset");

endmodule : hlt_timer

// >>> bench/hlt_trig_src.sv
// External trigger source model for the timer control bench
`timescale 1ns/10ps

module hlt_trig_src
(
  // Clock
  input wire logic sys_clk,
  // Level requested by the bench
  input wire logic trig_req,
  // Line toward the timer
  output logic external_trigger_signal
);
  // ==========================================================================
  // Driver
  logic trig_q;

  // Request taken on the rising edge so it never races the bench's own
  // falling-edge drive; the line then moves half a period later, away
  // from the instant the synchroniser samples it
  always @(posedge sys_clk)
  begin
    trig_q <= trig_req;
  end
  always @(negedge sys_clk)
  begin
    external_trigger_signal <= trig_q;
  end
endmodule : hlt_trig_src

// >>> bench/tb_hlt_timer.sv
// Self-checking bench for the hardware limit timer control block
`timescale 1ns/10ps
`include "hlt_cfg.svh"

module tb_hlt_timer;
  logic sys_clk;
  logic rst_n;
  logic timer_tick;
  logic sw_on_set;
  logic sw_on_clr;
  hlt_pkg::hlt_cfg_s cfg;
  logic sleep;
  logic trig_req;
  logic ext_sig;
  hlt_pkg::hlt_stat_s stat;
  int err_count;
  int checked;
  logic [7:0] held;
  logic [7:0] per;
  int i;

  // ==========================================================================
  // Instances
  hlt_timer i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .timer_tick(timer_tick),
    .sw_on_set(sw_on_set), .sw_on_clr(sw_on_clr), .cfg(cfg), .sleep(sleep),
    .external_trigger_signal(ext_sig), .stat(stat));
  hlt_trig_src i_src (.sys_clk(sys_clk), .trig_req(trig_req),
    .external_trigger_signal(ext_sig));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Helpers
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp8

  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask : cmp1

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic do_reset(input logic [4:0] m, input logic [7:0] p);
    @(negedge sys_clk);
    rst_n = 1'b0;
    cfg.mode = m;
    cfg.period_value = p;
    cyc(4);
    rst_n = 1'b1;
    cyc(1);
  endtask : do_reset

  task automatic sw_pulse(input logic on);
    if (on)
      sw_on_set = 1'b1;
    else
      sw_on_clr = 1'b1;
    cyc(1);
    sw_on_set = 1'b0;
    sw_on_clr = 1'b0;
  endtask : sw_pulse

  // Match pulse comes with the count already cleared, so keep the count
  // seen one cycle earlier
  task automatic wait_match(output logic [7:0] prev);
    int k;
    prev = stat.count_value;
    for (k = 0; k < 400 && stat.period_match !== 1'b1; k++)
    begin
      prev = stat.count_value;
      cyc(1);
    end
    cmp1(stat.period_match, 1'b1);
  endtask : wait_match

  // Edge limit modes: reset count after a selected edge, then restart pulse
  task automatic edge_lim(input logic [4:0] m, input logic r, input logic f);
    do_reset(m, 8'hfa);
    trig_req = 1'b0;
    sw_pulse(1'b1);
    cyc(30);
    cmp1(stat.pwm_drive, 1'b0);
    trig_req = 1'b1;
    cyc(12);
    cmp1(stat.count_value < 8'h0c, r);
    cmp1(stat.pwm_drive, r);
    cyc(30);
    trig_req = 1'b0;
    cyc(12);
    cmp1(stat.count_value < 8'h0c, f);
  endtask : edge_lim

  // Level limit modes, reset level lvl
  task automatic lvl_lim(input logic [4:0] m, input logic lvl);
    trig_req = ~lvl;
    do_reset(m, 8'hfa);
    sw_pulse(1'b1);
    cyc(10);
    trig_req = lvl;
    cyc(8);
    cmp8(stat.count_value, 8'h00);
    cmp1(stat.pwm_drive, 1'b1);
    cyc(20);
    cmp8(stat.count_value, 8'h00);
    trig_req = ~lvl;
    cyc(9);
    cmp1(stat.count_value inside {[8'h01:8'h09]}, 1'b1);
    sw_pulse(1'b0);
    cyc(2);
    held = stat.count_value;
    trig_req = lvl;
    cyc(10);
    cmp8(stat.count_value, held);
    trig_req = ~lvl;
  endtask : lvl_lim

  // Edge start: one-shot clears run at match, monostable keeps it
  task automatic edge_start(input logic [4:0] m, input logic keep_on);
    trig_req = 1'b0;
    do_reset(m, 8'h10);
    sw_pulse(1'b1);
    cyc(10);
    cmp8(stat.count_value, 8'h00);
    trig_req = 1'b1;
    wait_match(held);
    cmp8(held, 8'h10);
    cyc(1);
    cmp1(stat.on_bit, keep_on);
    cyc(10);
    cmp8(stat.count_value, 8'h00);
    trig_req = 1'b0;
  endtask : edge_start

  // ==========================================================================
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    timer_tick = 1'b1;
    sw_on_set = 1'b0;
    sw_on_clr = 1'b0;
    cfg = '0;
    cfg.pulse_width_value = 8'h14;
    sleep = 1'b0;
    trig_req = 1'b0;
    err_count = 0;
    checked = 0;
    void'($urandom(17));
    cyc(4);
    rst_n = 1'b1;
    cyc(1);
    cmp1(stat.on_bit, 1'b0);
    cmp8(stat.count_value, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      per = 8'h04 + 8'($urandom_range(36));
      do_reset(`HLT_MODE_OS_SW, per);
      sw_pulse(1'b1);
      wait_match(held);
      cmp8(held, per);
      cmp8(stat.count_value, 8'h00);
      cyc(1);
      cmp8(stat.count_value, 8'h00);
      cmp1(stat.on_bit, 1'b0);
      cyc(10);
      cmp8(stat.count_value, 8'h00);
      sw_pulse(1'b1);
      cyc(3);
      sw_pulse(1'b0);
      held = stat.count_value;
      cyc(5);
      cmp8(stat.count_value, held);
    end
    edge_lim(`HLT_MODE_LIM_ANY, 1'b1, 1'b1);
    edge_lim(5'h04, 1'b1, 1'b0);
    edge_lim(`HLT_MODE_LIM_FALL, 1'b0, 1'b1);
    lvl_lim(`HLT_MODE_LVL_LOW, 1'b0);
    lvl_lim(`HLT_MODE_LVL_HIGH, 1'b1);
    edge_start(`HLT_MODE_OS_RISE, 1'b0);
    edge_start(`HLT_MODE_MONO_RISE, 1'b1);
    // Edge limit one-shot: first rise starts, a later rise resets
    do_reset(`HLT_MODE_ELOS_RISE, 8'hfa);
    sw_pulse(1'b1);
    trig_req = 1'b1;
    cyc(20);
    cmp1(stat.count_value > 8'h08, 1'b1);
    trig_req = 1'b0;
    cyc(10);
    trig_req = 1'b1;
    cyc(12);
    cmp1(stat.count_value < 8'h0c, 1'b1);
    cmp1(stat.pwm_drive, 1'b1);
    trig_req = 1'b0;
    do_reset(`HLT_MODE_SW_GATE, 8'hfa);
    cfg.prescaler_sync_enable = 1'b1;
    cfg.internal_osc_selected = 1'b1;
    sw_pulse(1'b1);
    cyc(10);
    sleep = 1'b1;
    cyc(1);
    held = stat.count_value;
    cyc(10);
    cmp8(stat.count_value, held);
    cmp1(stat.osc_keep_alive, 1'b0);
    cfg.prescaler_sync_enable = 1'b0;
    cyc(5);
    cmp1(stat.count_value != held, 1'b1);
    cmp1(stat.osc_keep_alive, 1'b1);
    sleep = 1'b0;
    complete_run();
  end

  // ==========================================================================
  // Watchdog, well beyond the fewer than one thousand cycles the tests need
  initial
  begin
    #(40 * 20000);
    err_count++;
    complete_run();
  end
endmodule : tb_hlt_timer
